// ===== src/voice_playback.sv
// Purpose: Four-channel voice playback engine with push-pull output
// Assumes: Sample memory answers a fetch in the next cycle
// Notes: Registers sit on a plain strobe port, read data one cycle later
// Summary of operation
// - Four independent rate counters, one per channel.
// - Channel 0 to 2 rates programmable between 4 kHz and 40 kHz; channel 3 has no period register and stays at 40 kHz.
// - Sampling period set in quarter-microsecond steps.
// - Channels 0 to 2 loop a set section in hardware without software; channel 3 has no loop registers and loops address 0 only.
// - Loop section may be any length the address space holds.
// - Event tags in wave data are reported to software.
// - Push-pull output has eight bits with the low bit zero.
// - Volume bits 2..0 pick eight levels, code seven loudest.
// - Volume bit three halves the output level.
// - Samples scaled by a six-bit by eight-bit multiplier.
// - Two mixers saturate at full scale rather than wrap.
// - Speaker driven differentially, positive and negative phase.
//
// Added by the designer: the plain strobed port and the address map.
`include "voice_defines.svh"
module voice_playback
    import voice_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int STEP_CYC = `STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [CHANNELS-1:0] fetch_req,
    output logic [CHANNELS-1:0][15:0] fetch_addr,
    input wire logic [CHANNELS-1:0][8:0] fetch_data,
    output logic [7:0] speaker_drive_pos,
    output logic [7:0] speaker_drive_neg,
    output logic mark_pending
);
    localparam int SW = $clog2(STEP_CYC + 1);

    typedef struct packed {
        logic [SW-1:0] step;
        period_t cnt;
        period_t period;
        logic [5:0] gain;
        addr_t loop_start;
        addr_t loop_end;
        addr_t addr;
        logic [7:0] sample;
        logic run;
        logic repeat_on;
        logic fetch;
        // High while the memory shows the word asked for one cycle earlier
        logic take;
    } chan_s;

    typedef struct packed {
        chan_s [CHANNELS-1:0] ch;
        logic [3:0] output_level_register;
        logic [7:0] mark_code;
        logic mark_valid;
        logic mark_lost;
        logic [15:0] rdata;
        logic [7:0] pos;
        logic [7:0] neg;
        logic pace_out;
    } top_state_s;

    top_state_s st_q, st_d;

    // Register decode
    logic wr_ch_sel, rd_ch_sel;
    logic [1:0] ch_idx, ch_field;
    assign wr_ch_sel = reg_addr >= `REG_CH_BASE;
    assign rd_ch_sel = wr_ch_sel;
    assign ch_idx = reg_addr[3:2] - 2'd1;
    assign ch_field = reg_addr[1:0];

    // Per-channel scaled samples
    logic [CHANNELS-1:0][13:0] scaled;
    logic [CHANNELS-1:0] tick;
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            logic [13:0] prod;
            // Six-bit gain on eight-bit sample; top 8 bits kept
            assign prod = 14'(st_q.ch[g].sample) * 14'(st_q.ch[g].gain);
            assign scaled[g] = prod;
            assign tick[g] = st_q.ch[g].run
                && (st_q.ch[g].step == SW'(STEP_CYC - 1))
                && (st_q.ch[g].cnt == '0);
            assign fetch_req[g] = st_q.ch[g].fetch;
            assign fetch_addr[g] = st_q.ch[g].addr;
        end
    endgenerate

    // Two saturating mixers, channels 0+1 and 2+3, then a final saturating sum
    logic [8:0] mix_a, mix_b, mix_f;
    logic [7:0] sat_a, sat_b, mixed;
    assign mix_a = {1'b0, scaled[0][13:6]} + {1'b0, scaled[1][13:6]};
    assign mix_b = {1'b0, scaled[2][13:6]} + {1'b0, scaled[3][13:6]};
    assign sat_a = mix_a[8] ? 8'hff : mix_a[7:0];
    assign sat_b = mix_b[8] ? 8'hff : mix_b[7:0];
    assign mix_f = {1'b0, sat_a} + {1'b0, sat_b};
    assign mixed = mix_f[8] ? 8'hff : mix_f[7:0];

    // Volume: eight levels by right shift, bit three halves once more
    // A shift of eight mutes fully; steps are 6 dB, not a fine taper
    logic [7:0] vol_out;
    logic [3:0] shamt;
    always_comb begin
        shamt = {1'b0, 3'd7 - st_q.output_level_register[2:0]};
        if (st_q.output_level_register[`VOL_HALF_BIT]) begin
            shamt = shamt + 4'd1;
        end
        vol_out = mixed >> shamt;
    end

    // Output FIFO: mixed samples enter on any channel tick, drain on pace
    // Coinciding ticks of several channels push only one mixed word
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic any_tick;
    assign any_tick = |tick;

    voice_fifo #(
        .WIDTH(8),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(any_tick),
        .in_ready(fifo_in_ready),
        .in_data(vol_out),
        .out_valid(fifo_out_valid),
        .out_ready(st_q.pace_out),
        .out_data(fifo_out_data)
    );

    always_comb begin
        st_d = st_q;
        st_d.pace_out = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            st_d.ch[i].fetch = 1'b0;
            // Memory answers one cycle after the request, so look then
            st_d.ch[i].take = st_q.ch[i].fetch;
            if (st_q.ch[i].run) begin
                // Quarter-microsecond prescaler per channel
                if (st_q.ch[i].step == SW'(STEP_CYC - 1)) begin
                    st_d.ch[i].step = '0;
                    if (st_q.ch[i].cnt == '0) begin
                        st_d.ch[i].cnt = st_q.ch[i].period - 1'b1;
                    end else begin
                        st_d.ch[i].cnt = st_q.ch[i].cnt - 1'b1;
                    end
                end else begin
                    st_d.ch[i].step = st_q.ch[i].step + 1'b1;
                end
            end
            // A full FIFO holds each ticking channel at its tick so samples are never dropped
            if (tick[i] && fifo_in_ready) begin
                st_d.ch[i].fetch = 1'b1;
                if (st_q.ch[i].addr == st_q.ch[i].loop_end) begin
                    if (st_q.ch[i].repeat_on) begin
                        st_d.ch[i].addr = st_q.ch[i].loop_start;
                    end else begin
                        st_d.ch[i].run = 1'b0;
                        st_d.ch[i].fetch = 1'b0;
                    end
                end else begin
                    st_d.ch[i].addr = st_q.ch[i].addr + 1'b1;
                end
            end else if (tick[i]) begin
                st_d.ch[i].step = st_q.ch[i].step;
                st_d.ch[i].cnt = st_q.ch[i].cnt;
            end
            if (st_q.ch[i].take) begin
                if (fetch_data[i][8]) begin
                    // Tag words carry a code, not audio; the sample holds
                    if (st_q.mark_valid) begin
                        st_d.mark_lost = 1'b1;
                    end
                    st_d.mark_code = fetch_data[i][7:0];
                    st_d.mark_valid = 1'b1;
                end else begin
                    st_d.ch[i].sample = fetch_data[i][7:0];
                end
            end
        end
        if (any_tick) begin
            st_d.pace_out = 1'b1;
        end

        st_d.rdata = '0;
        if (reg_rd) begin
            if (rd_ch_sel) begin
                case (ch_field)
                    `CH_PERIOD: st_d.rdata = st_q.ch[ch_idx].period;
                    `CH_GAIN: st_d.rdata = {10'h000, st_q.ch[ch_idx].gain};
                    `CH_LOOP: st_d.rdata = st_q.ch[ch_idx].loop_start;
                    default: st_d.rdata = st_q.ch[ch_idx].loop_end;
                endcase
            end else begin
                case (reg_addr)
                    `REG_VOLUME:
                        st_d.rdata = {12'h000, st_q.output_level_register};
                    `REG_MARK: begin
                        st_d.rdata = {7'h00, st_q.mark_valid,
                            st_q.mark_code};
                        st_d.mark_valid = 1'b0;
                        st_d.mark_lost = 1'b0;
                    end
                    `REG_STATUS: begin
                        st_d.rdata = 16'h0000;
                        for (int i = 0; i < CHANNELS; i++) begin
                            st_d.rdata[i] = st_q.ch[i].run;
                        end
                        st_d.rdata[8] = st_q.mark_lost;
                    end
                    default: st_d.rdata = 16'h0000;
                endcase
            end
            // A tag fetched in the clearing cycle survives the clear
            for (int i = 0; i < CHANNELS; i++) begin
                if (st_q.ch[i].take && fetch_data[i][8]) begin
                    st_d.mark_valid = 1'b1;
                end
            end
        end

        if (reg_wr) begin
            if (wr_ch_sel) begin
                case (ch_field)
                    `CH_PERIOD: begin
                        // Clamp keeps the rate within 4 kHz..40 kHz
                        if (reg_wdata < `MIN_PERIOD_STEPS) begin
                            st_d.ch[ch_idx].period = `MIN_PERIOD_STEPS;
                        end else if (reg_wdata > `MAX_PERIOD_STEPS) begin
                            st_d.ch[ch_idx].period = `MAX_PERIOD_STEPS;
                        end else begin
                            st_d.ch[ch_idx].period = reg_wdata;
                        end
                    end
                    `CH_GAIN: st_d.ch[ch_idx].gain = reg_wdata[5:0];
                    `CH_LOOP: st_d.ch[ch_idx].loop_start = reg_wdata;
                    default: st_d.ch[ch_idx].loop_end = reg_wdata;
                endcase
            end else if (reg_addr == `REG_VOLUME) begin
                st_d.output_level_register = reg_wdata[3:0];
            end else if (reg_addr == `REG_CTRL) begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (reg_wdata[i] && !st_q.ch[i].run) begin
                        st_d.ch[i].run = 1'b1;
                        st_d.ch[i].addr = st_q.ch[i].loop_start;
                        st_d.ch[i].cnt = st_q.ch[i].period - 1'b1;
                        st_d.ch[i].step = '0;
                    end else if (!reg_wdata[i]) begin
                        st_d.ch[i].run = 1'b0;
                    end
                    st_d.ch[i].repeat_on = reg_wdata[i+4];
                end
            end
        end

        if (fifo_out_valid && st_q.pace_out) begin
            st_d.pos = {fifo_out_data[7:1], 1'b0};
            st_d.neg = ~{fifo_out_data[7:1], 1'b1};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.output_level_register <= `VOL_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                st_q.ch[i].period <= `MIN_PERIOD_STEPS;
            end
            st_q.neg <= 8'hfe;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign speaker_drive_pos = st_q.pos;
    assign speaker_drive_neg = st_q.neg;
    assign mark_pending = st_q.mark_valid;
endmodule : voice_playback

// ===== src/voice_defines.svh
// Purpose: Constants of the four-channel voice playback engine
// Assumes: 100 MHz ref_clk; register indices are our own map
// Notes: Included by the top module, the checker and the testbench
`ifndef VOICE_DEFINES_SVH
`define VOICE_DEFINES_SVH
`define CLK_PERIOD_PS 10000
`define PERIOD_STEP_PS 250000
`define STEP_CYCLES (((`PERIOD_STEP_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define MIN_RATE_HZ 4000
`define MAX_RATE_HZ 40000
`define MIN_PERIOD_STEPS 16'd100
`define MAX_PERIOD_STEPS 16'd1000
`define REG_VOLUME 4'h0
`define REG_MARK 4'h1
`define REG_STATUS 4'h2
`define REG_CTRL 4'h3
`define REG_CH_BASE 4'h4
`define CH_PERIOD 2'h0
`define CH_GAIN 2'h1
`define CH_LOOP 2'h2
`define CH_END 2'h3
`define VOL_RESET 4'h7
`define VOL_HALF_BIT 3
`define MARK_FLAG 8'h80
`define FIFO_DEPTH 8
`endif

// ===== src/voice_pkg.sv
// Purpose: Types of the voice playback engine
// Assumes: Constants come from voice_defines.svh
// Notes: Sample words carry a mark flag in bit 8
package voice_pkg;
    typedef logic [15:0] period_t;
    typedef logic [15:0] addr_t;
    typedef struct packed {
        logic mark;
        logic [7:0] data;
    } sample_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : voice_pkg

// ===== src/voice_fifo.sv
// Purpose: Parameterised FIFO holding mixed output samples
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full and empty are exact; no write when full, no read when empty
module voice_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_s;
    fifo_state_s st_q, st_d;
    logic do_wr, do_rd;

    assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data = st_q.mem[st_q.rp];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (do_wr) begin
            st_d.mem[st_q.wp] = in_data;
            st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
        end
        if (do_rd) begin
            st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
        end
        case ({do_wr, do_rd})
            2'b10: st_d.cnt = st_q.cnt + 1'b1;
            2'b01: st_d.cnt = st_q.cnt - 1'b1;
            default: st_d.cnt = st_q.cnt;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : voice_fifo

// ===== verification/voice_playback_sva.sv
// Purpose: Port checker for the voice playback engine
// Assumes: Bound from the testbench top file
// Notes: Gap counter follows channel 0 only, to keep helper logic small
`include "voice_defines.svh"
module voice_playback_sva
    import voice_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int STEP_CYC = 25
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [CHANNELS-1:0] fetch_req,
    input wire logic [CHANNELS-1:0][8:0] fetch_data,
    input wire logic [7:0] speaker_drive_pos,
    input wire logic [7:0] speaker_drive_neg,
    input wire logic mark_pending
);
    localparam int MIN_GAP = 100 * STEP_CYC - 1;
    int gap_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Saturates so a long stop never wraps into a short gap
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= 0;
        end else if (fetch_req[0]) begin
            gap_q <= 0;
        end else if (gap_q < 1000000) begin
            gap_q <= gap_q + 1;
        end
    end
    sequence s_tag;
        fetch_req[2] ##1 fetch_data[2][8];
    endsequence
    property p_low_bit;
        !speaker_drive_pos[0] && !speaker_drive_neg[0];
    endproperty
    property p_phase;
        speaker_drive_neg == {~speaker_drive_pos[7:1], 1'b0};
    endproperty
    property p_vol_width;
        reg_rd && reg_addr == `REG_VOLUME |=> reg_rdata[15:4] == 12'h000;
    endproperty
    property p_run_width;
        reg_rd && reg_addr == `REG_STATUS |=>
            reg_rdata[15:9] == 7'h00 && reg_rdata[7:4] == 4'h0;
    endproperty
    property p_fetch_pulse;
        fetch_req[0] |=> !fetch_req[0] [*8];
    endproperty
    property p_min_gap;
        fetch_req[0] |-> gap_q >= MIN_GAP;
    endproperty
    property p_tag_seen;
        s_tag |-> ##[1:2] mark_pending;
    endproperty
    property p_tag_read;
        reg_rd && reg_addr == `REG_MARK && mark_pending |=> reg_rdata[8];
    endproperty
    a_low_bit: assert property (p_low_bit)
        else $error("speaker low bit not zero");
    a_phase: assert property (p_phase)
        else $error("negative phase not inverse of positive");
    a_vol_width: assert property (p_vol_width)
        else $error("volume read wider than four bits");
    a_run_width: assert property (p_run_width)
        else $error("status read has stray bits");
    a_fetch_pulse: assert property (p_fetch_pulse)
        else $error("fetch request longer than one cycle");
    a_min_gap: assert property (p_min_gap)
        else $error("fetches closer than shortest period");
    a_tag_seen: assert property (p_tag_seen)
        else $error("tag word did not raise pending flag");
    a_tag_read: assert property (p_tag_read)
        else $error("pending tag read without valid bit");
endmodule : voice_playback_sva

// ===== verification/sample_mem_model.sv
// Purpose: Sample memory answering the engine's fetch requests
// Assumes: One word per fetch, shown in the cycle after the request
// Notes: Idle cycles invert the value shown the cycle before, never a held value
module sample_mem_model #(
    parameter logic [15:0] TAG_ADDR = 16'h0012
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] fetch_req,
    input wire logic [3:0][15:0] fetch_addr,
    output logic [3:0][8:0] fetch_data
);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_data <= '0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (!fetch_req[c]) begin
                    fetch_data[c] <= ~fetch_data[c];
                end else if (fetch_addr[c] == TAG_ADDR) begin
                    fetch_data[c] <= 9'h15a;
                end else begin
                    fetch_data[c] <= 9'h0ff;
                end
            end
        end
    end
endmodule : sample_mem_model

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the voice playback engine
// Assumes: Short step parameter; samples are full scale except one tag
// Notes: Speaker checks wait ten periods so the FIFO has flushed
`include "voice_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 2;
    localparam int PER = 100 * STEP;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] fetch_req;
    logic [3:0][15:0] fetch_addr;
    logic [3:0][8:0] fetch_data;
    logic [7:0] speaker_drive_pos;
    logic [7:0] speaker_drive_neg;
    logic mark_pending;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    int cnt0 = 0;
    int cnt1 = 0;
    logic [15:0] addr_log[$];
    always #5 ref_clk = ~ref_clk;
    voice_playback #(.STEP_CYC(STEP)) dut (.ref_clk, .rst_b, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fetch_req, .fetch_addr,
        .fetch_data, .speaker_drive_pos, .speaker_drive_neg, .mark_pending);
    sample_mem_model mem (.ref_clk, .rst_b, .fetch_req, .fetch_addr,
        .fetch_data);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (fetch_req[0]) cnt0 <= cnt0 + 1;
        if (fetch_req[1]) cnt1 <= cnt1 + 1;
        if (fetch_req[0]) addr_log.push_back(fetch_addr[0]);
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] got,
                       input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input string n, input logic [3:0] a,
                        input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(n, reg_rdata, exp);
    endtask : rchk
    task automatic chan(input int c, input int per, input int g,
                        input logic [15:0] s, input logic [15:0] e);
        wr(4'(4 + 4 * c), 16'(per));
        wr(4'(5 + 4 * c), 16'(g));
        wr(4'(6 + 4 * c), s);
        wr(4'(7 + 4 * c), e);
    endtask : chan
    task automatic wait_h(input int n);
        repeat (n * PER / 2) @(posedge ref_clk);
        #1;
    endtask : wait_h
    initial begin
        int s0;
        int s1;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rchk("volume", `REG_VOLUME, 16'h0007);
        rchk("period", 4'h4, 16'd100);
        wr(4'h4, 16'd50);
        rchk("period_lo", 4'h4, 16'd100);
        wr(4'h4, 16'd2000);
        rchk("period_hi", 4'h4, 16'd1000);
        $display("test reset_clamp done");
        chan(0, 100, 0, 16'h0000, 16'hffff);
        chan(1, 200, 0, 16'h0000, 16'hffff);
        wr(`REG_CTRL, 16'h0033);
        for (int i = 0; i < 2 * PER; i++) begin
            @(posedge ref_clk);
            #1;
            if (fetch_req[0]) break;
        end
        s0 = cnt0;
        s1 = cnt1;
        repeat (PER * 19 / 2) @(posedge ref_clk);
        chk("rate0", 16'(cnt0 - s0), 16'd10);
        chk("rate1", 16'(cnt1 - s1), 16'd5);
        $display("test rates done");
        wr(`REG_CTRL, 16'h0000);
        chan(0, 100, 0, 16'h0020, 16'h0022);
        addr_log.delete();
        wr(`REG_CTRL, 16'h0011);
        wait_h(17);
        chk("loop_len", 16'(addr_log.size()), 16'd8);
        for (int i = 1; i < addr_log.size(); i++) begin
            chk("loop_addr", addr_log[i], addr_log[i-1] == 16'h0022 ?
                16'h0020 : addr_log[i-1] + 16'h0001);
        end
        wr(`REG_CTRL, 16'h0001);
        wait_h(10);
        rchk("stopped", `REG_STATUS, 16'h0000);
        $display("test loop done");
        chan(0, 100, 63, 16'h0040, 16'h0041);
        wr(`REG_CTRL, 16'h0011);
        for (int l = 0; l < 8; l++) begin
            wr(`REG_VOLUME, 16'(l));
            wait_h(20);
            chk("level", 16'(speaker_drive_pos),
                16'((8'hfb >> (7 - l)) & 8'hfe));
        end
        wr(`REG_VOLUME, 16'h000f);
        wait_h(20);
        chk("half", 16'(speaker_drive_pos), 16'h007c);
        chk("neg", 16'(speaker_drive_neg), 16'h0082);
        wr(`REG_VOLUME, 16'h0007);
        chan(1, 100, 63, 16'h0040, 16'h0041);
        wr(`REG_CTRL, 16'h0033);
        wait_h(20);
        chk("saturate", 16'(speaker_drive_pos), 16'h00fe);
        $display("test volume_mix done");
        chan(2, 100, 0, 16'h0010, 16'h0013);
        wr(`REG_CTRL, 16'h0044);
        for (int i = 0; i < 5 * PER && !mark_pending; i++) begin
            @(posedge ref_clk);
        end
        rchk("mark", `REG_MARK, 16'h015a);
        rchk("mark_clr", `REG_MARK, 16'h005a);
        $display("test tag done");
        give_verdict();
    end
endmodule : testbench
bind voice_playback voice_playback_sva #(.CHANNELS(CHANNELS),
    .STEP_CYC(STEP_CYC)) sva_i (.ref_clk, .rst_b, .reg_addr, .reg_rd,
    .reg_rdata, .fetch_req, .fetch_data, .speaker_drive_pos,
    .speaker_drive_neg, .mark_pending);
